// *** src/sync_sram_pkg.sv ***
// Constants, types and state codes for the synchronous burst SRAM access logic.
// Assumes one clock and a bus master that runs on that same clock.

package sync_sram_pkg;

  localparam int ADDR_W  = 18;
  localparam int BURST_W = 2;
  localparam int HIGH_W  = ADDR_W - BURST_W;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int WORD_W  = DATA_W + LANES;
  localparam int DEPTH   = 1 << ADDR_W;

  // Parity bit of lane i sits at PARITY_POS + i in a stored word
  localparam int PARITY_POS = DATA_W;

  localparam logic [BURST_W-1:0] BURST_ONE      = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO     = 2'h0;
  localparam logic [LANES-1:0]   ALL_LANES      = 4'hf;
  localparam logic [LANES-1:0]   NO_LANES       = 4'h0;
  localparam logic               ORDER_RESET    = 1'b1;
  localparam logic [HIGH_W-1:0]  HIGH_RESET     = 16'h0000;
  localparam logic [WORD_W-1:0]  WORD_RESET     = 36'h000000000;

  typedef logic [ADDR_W-1:0]  addr_t;
  typedef logic [HIGH_W-1:0]  high_t;
  typedef logic [BURST_W-1:0] burst_t;
  typedef logic [WORD_W-1:0]  word_t;
  typedef logic [LANES-1:0]   lanes_t;

  // Gray order along deselect -> read -> write
  typedef enum logic [1:0] {
    DESELECTED = 2'b00,
    READING    = 2'b01,
    WRITING    = 2'b11
  } access_e;

endpackage

// *** src/sync_burst_counter.sv ***
// Two-bit wraparound burst position counter.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sync_burst_counter
  import sync_sram_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   load,
  input  wire burst_t load_value,
  input  wire logic   step,
  input  wire logic   interleave,
  output var  burst_t addr_low
);

  burst_t start;
  burst_t count;
  burst_t next_start;
  burst_t next_count;

  always_comb begin
    next_start = start;
    next_count = count;
    if (load) begin
      next_start = load_value;
      next_count = BURST_ZERO;
    end else if (step) begin
      next_count = count + BURST_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start <= BURST_ZERO;
      count <= BURST_ZERO;
    end else begin
      start <= next_start;
      count <= next_count;
    end
  end

  // Interleaved order is an xor of the step count, linear a modulo-four add
  assign addr_low = interleave ? (start ^ count) : burst_t'(start + count);

endmodule

`default_nettype wire

// *** src/sync_burst_sram_access.sv ***
// Synchronous access logic of a flow-through burst SRAM with common data I/O.
// Assumes the bus master shares MCLK; the output enable is asynchronous and the static strap is synchronised.
`timescale 1ns/1ps
`default_nettype none

module sync_burst_sram_access
  import sync_sram_pkg::*;
(
  input  wire logic               MCLK,
  input  wire logic               RESET_N,
  input  wire addr_t              ADDR,
  input  wire logic               SELECT_LOW_FIRST_N,
  input  wire logic               SELECT_HIGH_SECOND,
  input  wire logic               SELECT_LOW_THIRD_N,
  input  wire logic               PROCESSOR_ADDR_STROBE_N,
  input  wire logic               CONTROLLER_ADDR_STROBE_N,
  input  wire logic               BURST_STEP_N,
  input  wire logic               BYTE_WRITE_QUALIFIER_N,
  input  wire lanes_t             LANE_WRITE_SELECT_N,
  input  wire logic               GLOBAL_WRITE_ALL_N,
  input  wire logic               OUTPUT_ENABLE_N,
  input  wire logic               BURST_ORDER_STRAP,
  input  wire logic [DATA_W-1:0]  DATA_IN,
  output logic      [DATA_W-1:0]  DATA_OUT,
  output logic                    DATA_OE,
  input  wire lanes_t             PARITY_IN,
  output logic      [LANES-1:0]   PARITY_OUT,
  output logic                    PARITY_OE
);

  // Decode of the pins as they stand at the coming edge
  logic    selected;
  logic    proc_start;
  logic    ctrl_start;
  logic    load;
  logic    write_req;
  lanes_t  lanes_req;
  logic    step;

  // Registered state
  access_e state;
  access_e next_state;
  logic    first_clock;
  logic    next_first_clock;
  high_t   addr_high;
  high_t   next_addr_high;
  word_t   write_word;
  word_t   next_write_word;
  lanes_t  write_lanes;
  lanes_t  next_write_lanes;
  logic    order_meta;
  logic    order_interleave;
  burst_t  addr_low;
  addr_t   cur_addr;
  word_t   read_word;
  logic    drive;

  word_t   mem [DEPTH];

  always_comb begin
    selected   = !SELECT_LOW_FIRST_N && SELECT_HIGH_SECOND && !SELECT_LOW_THIRD_N;
    // Processor strobe is dead while the first select is high
    proc_start = !PROCESSOR_ADDR_STROBE_N && !SELECT_LOW_FIRST_N;
    ctrl_start = !CONTROLLER_ADDR_STROBE_N && !proc_start;
    load       = proc_start || ctrl_start;
    // Qualifier low with no lane chosen writes nothing
    write_req  = !GLOBAL_WRITE_ALL_N ||
                 (!BYTE_WRITE_QUALIFIER_N && (LANE_WRITE_SELECT_N != ALL_LANES));
    if (!GLOBAL_WRITE_ALL_N) begin
      lanes_req = ALL_LANES;
    end else if (!BYTE_WRITE_QUALIFIER_N) begin
      lanes_req = ~LANE_WRITE_SELECT_N;
    end else begin
      lanes_req = NO_LANES;
    end
    step = !load && (state != DESELECTED) && !BURST_STEP_N;
  end

  always_comb begin
    next_state       = state;
    next_first_clock = 1'b0;
    next_addr_high   = addr_high;
    next_write_word  = {PARITY_IN, DATA_IN};
    next_write_lanes = lanes_req;
    if (load) begin
      next_addr_high = ADDR[ADDR_W-1:BURST_W];
      if (!selected) begin
        next_state = DESELECTED;
      end else if (ctrl_start && write_req) begin
        next_state = WRITING;
      end else begin
        // A processor start ignores the write inputs on its first clock
        next_state = READING;
      end
      next_first_clock = selected && (state == DESELECTED);
    end else if (state != DESELECTED) begin
      next_state = write_req ? WRITING : READING;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state       <= DESELECTED;
      first_clock <= 1'b0;
      addr_high   <= HIGH_RESET;
      write_word  <= WORD_RESET;
      write_lanes <= NO_LANES;
    end else begin
      state       <= next_state;
      first_clock <= next_first_clock;
      addr_high   <= next_addr_high;
      write_word  <= next_write_word;
      write_lanes <= next_write_lanes;
    end
  end

  // Strap is static, but it still comes from a pin, so it is synchronised
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      order_meta       <= ORDER_RESET;
      order_interleave <= ORDER_RESET;
    end else begin
      order_meta       <= BURST_ORDER_STRAP;
      order_interleave <= order_meta;
    end
  end

  sync_burst_counter u_counter (
    .clk        (MCLK),
    .rst_n      (RESET_N),
    .load       (load),
    .load_value (ADDR[BURST_W-1:0]),
    .step       (step),
    .interleave (order_interleave),
    .addr_low   (addr_low)
  );

  assign cur_addr = {addr_high, addr_low};

  // Write data was captured one edge earlier, so a stepped burst stores
  // at the advanced address; the array itself is written without any strobe
  always_ff @(posedge MCLK) begin
    if (state == WRITING) begin
      for (int i = 0; i < LANES; i++) begin
        if (write_lanes[i]) begin
          mem[cur_addr][i*LANE_W +: LANE_W]  <= write_word[i*LANE_W +: LANE_W];
          mem[cur_addr][PARITY_POS + i]      <= write_word[PARITY_POS + i];
        end
      end
    end
  end

  // Flow-through: the array word appears in the cycle after the edge
  assign read_word = mem[cur_addr];

  // Write cycles float regardless of the output enable
  assign drive      = (state == READING) && !first_clock && !OUTPUT_ENABLE_N;
  assign DATA_OE    = drive;
  assign PARITY_OE  = drive;
  assign DATA_OUT   = drive ? read_word[DATA_W-1:0] : '0;
  assign PARITY_OUT = drive ? read_word[PARITY_POS +: LANES] : '0;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  sequence s_load_01;
    load && selected && ADDR[BURST_W-1:0] == 2'h1 && order_interleave;
  endsequence

  sequence s_step_on;
    step && !BURST_STEP_N;
  endsequence

  sequence s_proc_start;
    proc_start && selected;
  endsequence

  property p_interleave_walk;
    s_load_01 ##1 s_step_on ##1 s_step_on |=> addr_low == 2'h3;
  endproperty

  property p_proc_then_write;
    s_proc_start ##1 (!load && write_req) |=> state == WRITING && !DATA_OE;
  endproperty

  a_interleave_walk:
    assert property (p_interleave_walk)
      else $error("interleaved burst from 01 did not reach 11");

  a_linear_step:
    assert property (load && selected && !order_interleave && ADDR[1:0] == 2'h3
                     ##1 s_step_on |=> addr_low == 2'h0)
      else $error("linear burst did not wrap 11 to 00 on step");

  a_proc_write_next:
    assert property (p_proc_then_write)
      else $error("write inputs after processor start did not make a write");

  a_proc_ignores_write:
    assert property (s_proc_start |=> state == READING)
      else $error("processor start did not ignore write inputs");

  a_strobe_priority:
    assert property (s_proc_start and (!CONTROLLER_ADDR_STROBE_N && write_req)
                     |=> state != WRITING)
      else $error("controller strobe honoured alongside processor strobe");

  a_ctrl_write_start:
    assert property (selected && ctrl_start && write_req
                     |=> state == WRITING && cur_addr == $past(ADDR))
      else $error("controller write did not start at presented address");

  a_ctrl_write_store:
    assert property (selected && ctrl_start && !GLOBAL_WRITE_ALL_N
                     |=> write_lanes == ALL_LANES && write_word == $past({PARITY_IN, DATA_IN}))
      else $error("controller write did not capture bus data");

  a_read_start:
    assert property (selected && load && !(ctrl_start && write_req)
                     |=> state == READING && cur_addr == $past(ADDR))
      else $error("read did not start with loaded address");

  a_burst_hold:
    assert property (!load && state != DESELECTED && BURST_STEP_N
                     |=> cur_addr == $past(cur_addr))
      else $error("burst address moved without step");

  a_upper_fixed:
    assert property (!load ##1 !load |-> addr_high == $past(addr_high))
      else $error("upper address bits changed within burst");

  a_write_floats:
    assert property (state == WRITING |-> !DATA_OE && !PARITY_OE)
      else $error("data lines driven during a write");

  a_first_clock_float:
    assert property (load && selected && state == DESELECTED |=> !DATA_OE [*1])
      else $error("outputs driven on first clock after deselect");

  a_deselect_float:
    assert property (load && !selected |=> state == DESELECTED ##0 !DATA_OE)
      else $error("deselected device drives data lines");

  a_oe_gates_read:
    assert property (state == READING && !first_clock && !OUTPUT_ENABLE_N |-> DATA_OE)
      else $error("read data not driven with output enable low");

  a_parity_follows:
    assert property (PARITY_OE == DATA_OE)
      else $error("parity lines do not follow data lines");

  a_global_all_lanes:
    assert property (!GLOBAL_WRITE_ALL_N |-> lanes_req == ALL_LANES)
      else $error("global write did not select all lanes");

  a_lane_qualifier:
    assert property (GLOBAL_WRITE_ALL_N && BYTE_WRITE_QUALIFIER_N |-> !write_req)
      else $error("write detected without qualifier or global write");

endmodule

`default_nettype wire

// *** tb/bus_master.sv ***
// Bus master model driving the access pins of the burst SRAM block.
// Assumes the block samples on rising MCLK; pins change on falling MCLK.
`timescale 1ns/1ps
`default_nettype none

module bus_master
  import sync_sram_pkg::*;
(
  input  wire logic              mclk,
  output var  addr_t             addr,
  output logic [2:0]             sel,
  output logic [4:0]             ctl,
  output var  lanes_t            lane_n,
  output logic                   oe_n,
  output logic                   strap,
  output logic [DATA_W-1:0]      din,
  output var  lanes_t            pin
);
  logic  order = 1'b1;
  word_t last  = WORD_RESET;

  // Only changed while reset is held
  assign strap = order;

  initial begin
    addr   = 18'h0;
    sel    = 3'h2;
    ctl    = 5'h1f;
    lane_n = 4'hf;
    oe_n   = 1'b0;
    {pin, din} = WORD_RESET;
  end

  // ctl = {proc strobe, ctrl strobe, step, global, qualifier}, all active low
  // sel = {select 1 n, select 2, select 3 n}
  task automatic cyc(input logic [4:0] c, input logic [2:0] s, input addr_t a,
                     input lanes_t l, input logic drv, input word_t d);
    @(negedge mclk);
    ctl    = c;
    sel    = s;
    addr   = a;
    lane_n = l;
    // Output enable high whenever our data is on the bus
    oe_n   = drv;
    if (drv) begin
      last = d;
    end
    // Released bus shows no stale value
    {pin, din} = drv ? d : ~last;
    @(posedge mclk);
    #1;
  endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the burst SRAM access block.
// Assumes the bus master model owns all pins except clock and reset.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import sync_sram_pkg::*;
;
  localparam addr_t BASE = 18'h2a5c4;
  localparam word_t BW   = 36'h6a5b4c3d2;
  logic              mclk    = 1'b0;
  logic              reset_n = 1'b0;
  addr_t             addr;
  logic [2:0]        sel;
  logic [4:0]        ctl;
  lanes_t            lane_n;
  logic              oe_n;
  logic              strap;
  logic [DATA_W-1:0] din;
  lanes_t            pin;
  logic [DATA_W-1:0] dout;
  lanes_t            pout;
  logic              doe;
  logic              poe;
  word_t             mem [4];
  int                mismatches = 0;
  int                n_checks   = 0;

  initial begin
    forever #25 mclk = ~mclk;
  end

  bus_master bm_u (.mclk(mclk), .addr(addr), .sel(sel), .ctl(ctl), .lane_n(lane_n),
    .oe_n(oe_n), .strap(strap), .din(din), .pin(pin));

  sync_burst_sram_access dut_u (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr),
    .SELECT_LOW_FIRST_N(sel[2]), .SELECT_HIGH_SECOND(sel[1]), .SELECT_LOW_THIRD_N(sel[0]),
    .PROCESSOR_ADDR_STROBE_N(ctl[4]), .CONTROLLER_ADDR_STROBE_N(ctl[3]),
    .BURST_STEP_N(ctl[2]), .GLOBAL_WRITE_ALL_N(ctl[1]), .BYTE_WRITE_QUALIFIER_N(ctl[0]),
    .LANE_WRITE_SELECT_N(lane_n), .OUTPUT_ENABLE_N(oe_n), .BURST_ORDER_STRAP(strap),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .PARITY_IN(pin),
    .PARITY_OUT(pout), .PARITY_OE(poe));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t enable %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_oe(input logic e);
    cmp_bit(doe, e);
    cmp_bit(poe, e);
  endtask

  task automatic idle();
    bm_u.cyc(5'h1f, 3'h2, 18'h0, 4'hf, 1'b0, '0);
  endtask

  task automatic do_reset(input logic order);
    @(negedge mclk);
    reset_n = 1'b0;
    bm_u.order = order;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    // Strap is synchronised, so give it settling edges
    repeat (3) idle();
  endtask

  task automatic t_write_all();
    for (int i = 0; i < 4; i++) begin
      mem[i] = {4'h9 ^ 4'(i), 32'h5ac31e00 + 32'(i)};
      bm_u.cyc(5'h15, 3'h2, BASE + addr_t'(i), 4'h5, 1'b1, mem[i]);
      chk_oe(1'b0);
    end
    $display("write_all finished");
  endtask

  task automatic t_burst_read(input burst_t s, input logic lin, input logic fresh);
    burst_t k;
    burst_t a;
    bm_u.cyc(5'h17, 3'h2, BASE + addr_t'(s), 4'hf, 1'b0, '0);
    if (fresh) begin
      chk_oe(1'b0);
    end else begin
      cmp_word({pout, dout}, mem[s]);
    end
    for (int i = 1; i <= 4; i++) begin
      k = burst_t'(i);
      a = lin ? s + k : s ^ k;
      bm_u.cyc(5'h1b, 3'h2, 18'h0, 4'hf, 1'b0, '0);
      cmp_word({pout, dout}, mem[a]);
    end
    $display("burst_read finished");
  endtask

  task automatic t_deselect();
    bm_u.cyc(5'h17, 3'h0, BASE, 4'hf, 1'b0, '0);
    chk_oe(1'b0);
    bm_u.cyc(5'h0f, 3'h2, BASE + 18'h2, 4'hf, 1'b0, '0);
    chk_oe(1'b0);
    idle();
    cmp_word({pout, dout}, mem[2]);
    bm_u.cyc(5'h0f, 3'h6, BASE, 4'hf, 1'b0, '0);
    cmp_word({pout, dout}, mem[2]);
    bm_u.cyc(5'h05, 3'h2, BASE + 18'h3, 4'hf, 1'b0, '0);
    chk_oe(1'b1);
    cmp_word({pout, dout}, mem[3]);
    idle();
    cmp_word({pout, dout}, mem[3]);
    $display("deselect finished");
  endtask

  task automatic t_byte_write();
    word_t w;
    w = mem[0];
    bm_u.cyc(5'h0c, 3'h2, BASE, 4'h0, 1'b0, '0);
    cmp_word({pout, dout}, mem[0]);
    bm_u.cyc(5'h1e, 3'h2, 18'h0, 4'ha, 1'b1, BW);
    chk_oe(1'b0);
    for (int i = 0; i < LANES; i += 2) begin
      w[i*LANE_W +: LANE_W] = BW[i*LANE_W +: LANE_W];
      w[PARITY_POS + i] = BW[PARITY_POS + i];
    end
    mem[0] = w;
    idle();
    cmp_word({pout, dout}, mem[0]);
    // Lanes active but qualifier high: no write may happen
    bm_u.cyc(5'h1f, 3'h2, 18'h0, 4'h0, 1'b1, ~BW);
    chk_oe(1'b0);
    idle();
    cmp_word({pout, dout}, mem[0]);
    $display("byte_write finished");
  endtask

  initial begin
    #10000;
    mismatches++;
    complete_run();
  end

  initial begin
    do_reset(1'b1);
    t_write_all();
    t_burst_read(2'h1, 1'b0, 1'b0);
    t_deselect();
    t_byte_write();
    do_reset(1'b0);
    t_burst_read(2'h3, 1'b1, 1'b1);
    complete_run();
  end
endmodule

`default_nettype wire
